/* src/urt_runtime.v */
// Serial port runtime registers: data, enables, fifo control, identification.
// Assumes an AXI4-Lite master with one read and one write under way at most.
//
// Decided for this implementation: the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`include "urt_defs.vh"
module urt_runtime
#(
  parameter        ADDR_W     = 5,
  parameter        FIFO_DEPTH = 16,
  parameter        FIFO_AW    = 4,
  parameter [15:0] DIV_RST    = 16'h0001
)
(
  input  wire              aclk,
  input  wire              aresetn,
  input  wire [ADDR_W-1:0] s_axi_awaddr,
  input  wire              s_axi_awvalid,
  output wire              s_axi_awready,
  input  wire [31:0]       s_axi_wdata,
  input  wire [3:0]        s_axi_wstrb,
  input  wire              s_axi_wvalid,
  output wire              s_axi_wready,
  output reg  [1:0]        s_axi_bresp,
  output reg               s_axi_bvalid,
  input  wire              s_axi_bready,
  input  wire [ADDR_W-1:0] s_axi_araddr,
  input  wire              s_axi_arvalid,
  output wire              s_axi_arready,
  output reg  [31:0]       s_axi_rdata,
  output reg  [1:0]        s_axi_rresp,
  output reg               s_axi_rvalid,
  input  wire              s_axi_rready,
  input  wire              rxd,
  output reg               txd,
  input  wire              modem_change,
  output reg               serial_irq
);
  // ----------------------------------------------------------------------
  // Register state.
  // ----------------------------------------------------------------------
  reg  [3:0]         enables_r;
  reg  [7:0]         linefmt_r;
  reg  [15:0]        divisor_r;
  reg                fifos_enable_r;
  reg  [1:0]         trig_sel_r;
  reg                overrun_r;
  reg                frame_r;
  reg                break_r;
  reg                thre_pend_r;
  reg                tx_empty_d_r;
  reg                timeout_r;
  reg  [19:0]        tout_cnt_r;
  reg  [5:0]         tout_bits_r;

  // ----------------------------------------------------------------------
  // Bus channel state.
  // ----------------------------------------------------------------------
  reg                aw_got_r;
  reg                w_got_r;
  reg  [2:0]         waddr_r;
  reg  [7:0]         wdata_r;
  reg                wlane_r;
  reg                rd_pend_r;
  reg  [2:0]         raddr_r;
  reg  [7:0]         ident_snap_r;

  // ----------------------------------------------------------------------
  // Transmit serializer state.
  // ----------------------------------------------------------------------
  reg                tx_busy_r;
  reg  [9:0]         tx_sh_r;
  reg  [3:0]         tx_bits_r;
  reg  [19:0]        tx_cnt_r;

  wire               divsel;
  wire [19:0]        bit_period;
  wire               wr_fire;
  wire               ar_fire;
  wire               wr_data;
  wire               wr_fifo;
  wire               rd_data;
  wire               rd_lstat;
  wire               rd_ident;
  wire               rd_mapped;
  wire               fifo_flush_all;
  wire               rx_flush;
  wire               tx_flush;
  wire [7:0]         rx_head;
  wire [FIFO_AW:0]   rx_count;
  wire [7:0]         tx_head;
  wire [FIFO_AW:0]   tx_count;
  wire [FIFO_AW:0]   slot_limit;
  wire               rx_done;
  wire [7:0]         rx_char;
  wire               rx_ferr;
  wire               rx_brk;
  wire               rx_push;
  wire               rx_overrun;
  wire               tx_push;
  wire               tx_load;
  wire               tx_empty;
  reg  [FIFO_AW:0]   trig_level;
  reg  [3:0]         id_code;
  wire [7:0]         ident;
  wire               src_line;
  wire               src_rxdata;
  wire               src_tout;
  wire               src_thre;
  wire               src_modem;

  assign divsel     = linefmt_r[`URT_LF_DIVSEL];
  assign bit_period = {(divisor_r == 16'h0000) ? 16'h0001 : divisor_r, 4'h0};

  // ----------------------------------------------------------------------
  // Write channel: address and data taken in either order.
  // ----------------------------------------------------------------------
  assign s_axi_awready = !aw_got_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_got_r && !s_axi_bvalid;
  assign wr_fire       = aw_got_r && w_got_r && !s_axi_bvalid;
  assign wr_data       = wr_fire && wlane_r && (waddr_r == `URT_IDX_DATA) && !divsel;
  assign wr_fifo       = wr_fire && wlane_r && (waddr_r == `URT_IDX_FIFO);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_r     <= 1'b0;
      w_got_r      <= 1'b0;
      waddr_r      <= 3'h0;
      wdata_r      <= 8'h00;
      wlane_r      <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `URT_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_r <= 1'b1;
        waddr_r  <= s_axi_awaddr[4:2];
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_r <= 1'b1;
        wdata_r <= s_axi_wdata[7:0];
        wlane_r <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= (waddr_r <= `URT_IDX_LINEFMT || waddr_r == `URT_IDX_LSTAT) ?
                        `URT_RESP_OKAY : `URT_RESP_SLVERR;
      end
      else if (s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Control registers.
  // ----------------------------------------------------------------------
  assign fifo_flush_all = wr_fifo && !wdata_r[`URT_FC_ENABLE];
  assign rx_flush = fifo_flush_all || (wr_fifo && wdata_r[`URT_FC_RXCLR]);
  assign tx_flush = fifo_flush_all || (wr_fifo && wdata_r[`URT_FC_TXCLR]);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      enables_r      <= `URT_EN_RST;
      linefmt_r      <= `URT_LF_RST;
      divisor_r      <= DIV_RST;
      fifos_enable_r <= 1'b0;
      trig_sel_r     <= `URT_TRIG_RST;
    end
    else if (wr_fire && wlane_r)
    begin
      case (waddr_r)
        `URT_IDX_DATA:
          if (divsel)
            divisor_r[7:0] <= wdata_r;
        `URT_IDX_ENABLES:
          if (divsel)
            divisor_r[15:8] <= wdata_r;
          else
            enables_r <= wdata_r[3:0];
        `URT_IDX_FIFO:
        begin
          fifos_enable_r <= wdata_r[`URT_FC_ENABLE];
          if (wdata_r[`URT_FC_ENABLE])
            trig_sel_r <= wdata_r[7:6];
        end
        `URT_IDX_LINEFMT:
          linefmt_r <= wdata_r;
        default:
          linefmt_r <= linefmt_r;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // Receive path: shift register into the receive fifo.
  // ----------------------------------------------------------------------
  assign slot_limit = fifos_enable_r ? FIFO_DEPTH[FIFO_AW:0] : {{FIFO_AW{1'b0}}, 1'b1};
  assign rx_overrun = rx_done && (rx_count >= slot_limit);
  assign rx_push    = rx_done && !rx_overrun;
  assign rd_data    = rd_pend_r && (raddr_r == `URT_IDX_DATA) && !divsel;
  assign rd_lstat   = rd_pend_r && (raddr_r == `URT_IDX_LSTAT);
  assign rd_ident   = rd_pend_r && (raddr_r == `URT_IDX_FIFO);

  urt_rx u_rx
  (
    .aclk       (aclk),
    .aresetn    (aresetn),
    .rxd        (rxd),
    .bit_period (bit_period),
    .done       (rx_done),
    .data       (rx_char),
    .frame_err  (rx_ferr),
    .brk        (rx_brk)
  );

  urt_fifo #(.DW(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_rx_fifo
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .flush   (rx_flush),
    .push    (rx_push),
    .din     (rx_char),
    .pop     (rd_data),
    .dout    (rx_head),
    .count   (rx_count)
  );

  // ----------------------------------------------------------------------
  // Line errors and character timeout; a new line error beats a clear, a clear beats the timeout.
  // ----------------------------------------------------------------------
  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      overrun_r   <= 1'b0;
      frame_r     <= 1'b0;
      break_r     <= 1'b0;
      timeout_r   <= 1'b0;
      tout_cnt_r  <= 20'h0_0000;
      tout_bits_r <= 6'h00;
    end
    else
    begin
      overrun_r <= rx_overrun || (overrun_r && !rd_lstat);
      frame_r   <= (rx_done && rx_ferr) || (frame_r && !rd_lstat);
      break_r   <= (rx_done && rx_brk) || (break_r && !rd_lstat);
      if (rx_push || rd_data || rx_count == {(FIFO_AW+1){1'b0}} || !fifos_enable_r)
      begin
        tout_cnt_r  <= 20'h0_0000;
        tout_bits_r <= 6'h00;
        timeout_r   <= 1'b0;
      end
      else if (tout_bits_r == `URT_TOUT_BITS)
        timeout_r <= 1'b1;
      else if (tout_cnt_r == bit_period - 20'h0_0001)
      begin
        tout_cnt_r  <= 20'h0_0000;
        tout_bits_r <= tout_bits_r + 6'h01;
      end
      else
        tout_cnt_r <= tout_cnt_r + 20'h0_0001;
    end
  end

  // ----------------------------------------------------------------------
  // Transmit path: fifo into the serializer once it is idle.
  // ----------------------------------------------------------------------
  assign tx_push  = wr_data && (tx_count < slot_limit);
  assign tx_load  = !tx_busy_r && (tx_count != {(FIFO_AW+1){1'b0}});
  assign tx_empty = (tx_count == {(FIFO_AW+1){1'b0}});

  urt_fifo #(.DW(8), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_tx_fifo
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .flush   (tx_flush),
    .push    (tx_push),
    .din     (wdata_r),
    .pop     (tx_load),
    .dout    (tx_head),
    .count   (tx_count)
  );

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_busy_r <= 1'b0;
      tx_sh_r   <= 10'h3FF;
      tx_bits_r <= 4'h0;
      tx_cnt_r  <= 20'h0_0000;
      txd       <= 1'b1;
    end
    else if (tx_load)
    begin
      tx_busy_r <= 1'b1;
      tx_sh_r   <= {1'b1, tx_head, 1'b0};
      tx_bits_r <= 4'h0;
      tx_cnt_r  <= 20'h0_0000;
    end
    else if (tx_busy_r)
    begin
      txd <= tx_sh_r[0];
      if (tx_cnt_r == bit_period - 20'h0_0001)
      begin
        tx_cnt_r  <= 20'h0_0000;
        tx_sh_r   <= {1'b1, tx_sh_r[9:1]};
        tx_bits_r <= tx_bits_r + 4'h1;
        if (tx_bits_r == 4'h9)
          tx_busy_r <= 1'b0;
      end
      else
        tx_cnt_r <= tx_cnt_r + 20'h0_0001;
    end
    else
      txd <= 1'b1;
  end

  // ----------------------------------------------------------------------
  // Interrupt sources and identification.
  // ----------------------------------------------------------------------
  always @*
  begin
    case (trig_sel_r)
      2'h0:    trig_level = 5'h01;
      2'h1:    trig_level = 5'h04;
      2'h2:    trig_level = 5'h08;
      default: trig_level = 5'h0E;
    endcase
  end

  assign src_line   = enables_r[2] && (overrun_r || frame_r || break_r);
  assign src_rxdata = enables_r[0] && (fifos_enable_r ? (rx_count >= trig_level)
                                       : (rx_count != {(FIFO_AW+1){1'b0}}));
  assign src_tout   = enables_r[0] && fifos_enable_r && timeout_r;
  assign src_thre   = enables_r[1] && thre_pend_r;
  assign src_modem  = enables_r[3] && modem_change;

  always @*
  begin
    if (src_line)
      id_code = `URT_ID_LINE;
    else if (src_rxdata)
      id_code = `URT_ID_RXDATA;
    else if (src_tout)
      id_code = `URT_ID_TIMEOUT;
    else if (src_thre)
      id_code = `URT_ID_TXEMPTY;
    else if (src_modem)
      id_code = `URT_ID_MODEM;
    else
      id_code = `URT_ID_NONE;
  end

  assign ident = {fifos_enable_r, fifos_enable_r, 2'b00, id_code};

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      thre_pend_r  <= 1'b0;
      tx_empty_d_r <= 1'b1;
      serial_irq   <= 1'b0;
    end
    else
    begin
      tx_empty_d_r <= tx_empty;
      if (tx_empty && !tx_empty_d_r)
        thre_pend_r <= 1'b1;
      else if (wr_fire && wlane_r && !divsel && waddr_r == `URT_IDX_ENABLES &&
               wdata_r[1] && !enables_r[1] && tx_empty)
        thre_pend_r <= 1'b1;
      else if (wr_data || (rd_ident && ident_snap_r[3:0] == `URT_ID_TXEMPTY))
        thre_pend_r <= 1'b0;
      serial_irq <= (id_code != `URT_ID_NONE);
    end
  end

  // ----------------------------------------------------------------------
  // Read channel: address taken, answer two cycles after the handshake.
  // ----------------------------------------------------------------------
  assign s_axi_arready = !rd_pend_r && !s_axi_rvalid;
  assign ar_fire       = s_axi_arvalid && s_axi_arready;
  assign rd_mapped     = (raddr_r <= `URT_IDX_LINEFMT) || (raddr_r == `URT_IDX_LSTAT);

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rd_pend_r    <= 1'b0;
      raddr_r      <= 3'h0;
      ident_snap_r <= 8'h01;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= `URT_RESP_OKAY;
    end
    else
    begin
      if (ar_fire)
      begin
        rd_pend_r    <= 1'b1;
        raddr_r      <= s_axi_araddr[4:2];
        ident_snap_r <= ident;
      end
      if (rd_pend_r)
      begin
        rd_pend_r    <= 1'b0;
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= rd_mapped ? `URT_RESP_OKAY : `URT_RESP_SLVERR;
        case (raddr_r)
          `URT_IDX_DATA:
            s_axi_rdata <= {24'h00_0000, divsel ? divisor_r[7:0] : rx_head};
          `URT_IDX_ENABLES:
            s_axi_rdata <= {24'h00_0000, divsel ? divisor_r[15:8]
                                                : {4'h0, enables_r}};
          `URT_IDX_FIFO:
            s_axi_rdata <= {24'h00_0000, ident_snap_r};
          `URT_IDX_LINEFMT:
            s_axi_rdata <= {24'h00_0000, linefmt_r};
          `URT_IDX_LSTAT:
            s_axi_rdata <= {24'h00_0000, 1'b0, tx_empty && !tx_busy_r, tx_empty,
                            break_r, frame_r, 1'b0, overrun_r,
                            rx_count != {(FIFO_AW+1){1'b0}}};
          default:
            s_axi_rdata <= 32'h0000_0000;
        endcase
      end
      else if (s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end
endmodule

/* src/urt_defs.vh */
// Constants for the serial port runtime register block.
// Assumes an AXI4-Lite slave with 32-bit words, one register per word.
`ifndef URT_DEFS_VH
`define URT_DEFS_VH

// ----------------------------------------------------------------------
// Register indexes; byte address is four times the index.
// ----------------------------------------------------------------------
`define URT_IDX_DATA    3'h0
`define URT_IDX_ENABLES 3'h1
`define URT_IDX_FIFO    3'h2
`define URT_IDX_LINEFMT 3'h3
`define URT_IDX_LSTAT   3'h5

// ----------------------------------------------------------------------
// Field positions and reset values.
// ----------------------------------------------------------------------
`define URT_FC_ENABLE   0
`define URT_FC_RXCLR    1
`define URT_FC_TXCLR    2
`define URT_LF_DIVSEL   7
`define URT_EN_RST      4'h0
`define URT_LF_RST      8'h00
`define URT_TRIG_RST    2'h0

// ----------------------------------------------------------------------
// Identification codes and timing.
// ----------------------------------------------------------------------
`define URT_ID_NONE     4'h1
`define URT_ID_LINE     4'h6
`define URT_ID_RXDATA   4'h4
`define URT_ID_TIMEOUT  4'hC
`define URT_ID_TXEMPTY  4'h2
`define URT_ID_MODEM    4'h0
`define URT_TOUT_BITS   6'h28
`define URT_RESP_OKAY   2'h0
`define URT_RESP_SLVERR 2'h2

`endif

/* src/urt_fifo.v */
// Character fifo memory with a registered head word.
// Ignores a push when full and a pop when empty.
`timescale 1ns/1ns
module urt_fifo
#(
  parameter DW    = 8,
  parameter DEPTH = 16,
  parameter AW    = 4
)
(
  input  wire          aclk,
  input  wire          aresetn,
  input  wire          flush,
  input  wire          push,
  input  wire [DW-1:0] din,
  input  wire          pop,
  output reg  [DW-1:0] dout,
  output reg  [AW:0]   count
);
  localparam [AW:0] FULL = DEPTH[AW:0];

  reg  [DW-1:0] mem [0:DEPTH-1];
  reg  [AW-1:0] wr_ptr_r;
  reg  [AW-1:0] rd_ptr_r;
  wire          do_push;
  wire          do_pop;
  wire [AW-1:0] rd_ptr_nxt;

  assign do_push    = push && (count != FULL);
  assign do_pop     = pop && (count != {(AW+1){1'b0}});
  assign rd_ptr_nxt = flush ? {AW{1'b0}} : (do_pop ? rd_ptr_r + 1'b1 : rd_ptr_r);

  always @(posedge aclk)
  begin
    if (do_push && !flush)
      mem[wr_ptr_r] <= din;
  end

  always @(posedge aclk)
  begin
    if (!aresetn || flush)
    begin
      wr_ptr_r <= {AW{1'b0}};
      rd_ptr_r <= {AW{1'b0}};
      count    <= {(AW+1){1'b0}};
      dout     <= {DW{1'b0}};
    end
    else
    begin
      rd_ptr_r <= rd_ptr_nxt;
      if (do_push)
        wr_ptr_r <= wr_ptr_r + 1'b1;
      count <= count + {{AW{1'b0}}, do_push} - {{AW{1'b0}}, do_pop};
      if (do_push && (wr_ptr_r == rd_ptr_nxt))
        dout <= din;
      else
        dout <= mem[rd_ptr_nxt];
    end
  end
endmodule

/* src/urt_rx.v */
// Receive deserializer: start, eight data bits with bit 0 first, one stop.
// Assumes the line input is synchronous to aclk.
`timescale 1ns/1ns
module urt_rx
(
  input  wire        aclk,
  input  wire        aresetn,
  input  wire        rxd,
  input  wire [19:0] bit_period,
  output reg         done,
  output reg  [7:0]  data,
  output reg         frame_err,
  output reg         brk
);
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_START = 2'h1;
  localparam [1:0] ST_DATA  = 2'h2;
  localparam [1:0] ST_STOP  = 2'h3;

  reg [1:0]  st_r;
  reg [19:0] cnt_r;
  reg [2:0]  bits_r;
  reg [7:0]  sh_r;

  always @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_r      <= ST_IDLE;
      cnt_r     <= 20'h0_0000;
      bits_r    <= 3'h0;
      sh_r      <= 8'h00;
      done      <= 1'b0;
      data      <= 8'h00;
      frame_err <= 1'b0;
      brk       <= 1'b0;
    end
    else
    begin
      done <= 1'b0;
      if (st_r != ST_IDLE && cnt_r != 20'h0_0000)
        cnt_r <= cnt_r - 20'h0_0001;
      else
        case (st_r)
          ST_IDLE:
            if (!rxd)
            begin
              st_r  <= ST_START;
              cnt_r <= bit_period >> 1;
            end
          ST_START:
          begin
            st_r   <= rxd ? ST_IDLE : ST_DATA;
            cnt_r  <= bit_period - 20'h0_0001;
            bits_r <= 3'h0;
          end
          ST_DATA:
          begin
            sh_r   <= {rxd, sh_r[7:1]};
            bits_r <= bits_r + 3'h1;
            cnt_r  <= bit_period - 20'h0_0001;
            if (bits_r == 3'h7)
              st_r <= ST_STOP;
          end
          default:
          begin
            st_r      <= ST_IDLE;
            done      <= 1'b1;
            data      <= sh_r;
            frame_err <= !rxd;
            brk       <= !rxd && (sh_r == 8'h00);
          end
        endcase
    end
  end
endmodule

/* verif/urt_runtime_props.sv */
// Checker of the register bus answers of the runtime block.
// Assumes one bind to every instance of the runtime block.
`timescale 1ns/1ns
module urt_runtime_props
#(
  parameter ADDR_W = 5
)
(
  input wire              aclk,
  input wire              aresetn,
  input wire              s_axi_awvalid,
  input wire              s_axi_awready,
  input wire              s_axi_wvalid,
  input wire              s_axi_wready,
  input wire [1:0]        s_axi_bresp,
  input wire              s_axi_bvalid,
  input wire              s_axi_bready,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire              s_axi_arvalid,
  input wire              s_axi_arready,
  input wire [31:0]       s_axi_rdata,
  input wire [1:0]        s_axi_rresp,
  input wire              s_axi_rvalid,
  input wire              s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  wire ar_hs = s_axi_arvalid && s_axi_arready;
  property p_rd_lat;
    ar_hs |=> !s_axi_rvalid ##1 s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("Read answer off time.");
  property p_r_hold;
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_r_hold: assert property (p_r_hold) else $error("Read answer changed.");
  property p_ar_busy;
    s_axi_rvalid |-> !s_axi_arready;
  endproperty
  a_ar_busy: assert property (p_ar_busy) else $error("Read taken too soon.");
  property p_b_hold;
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_b_hold: assert property (p_b_hold) else $error("Write answer changed.");
  property p_wr_lat;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid;
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("Write answer late.");
  property p_b_busy;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_b_busy: assert property (p_b_busy) else $error("Write taken too soon.");
  property p_r_upper;
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h00_0000;
  endproperty
  a_r_upper: assert property (p_r_upper) else $error("Upper read bits set.");
  property p_slv;
    ar_hs && s_axi_araddr[4:2] > 3'h3 && s_axi_araddr[4:2] != 3'h5
      |-> ##2 s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0000_0000;
  endproperty
  a_slv: assert property (p_slv) else $error("Unmapped read answered.");
  cover property (ar_hs);
  cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
  cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule
bind urt_runtime urt_runtime_props #(.ADDR_W(ADDR_W)) props_u (.*);

/* verif/urt_peer.sv */
// Serial line peer: sends characters on rxd and collects those on txd.
// Assumes sixteen clocks per bit, eight data bits, one stop bit.
`timescale 1ns/1ns
module urt_peer
(
  input wire aclk,
  input wire txd,
  output reg rxd
);
  reg [7:0] got_q[$];
  reg [7:0] sh;
  integer   j;
  initial rxd = 1'b1;
  task send(input [7:0] d);
    reg [9:0] fr;
    integer   i;
    begin
      fr = {1'b1, d, 1'b0};
      for (i = 0; i < 10; i = i + 1)
      begin
        rxd <= fr[i];
        repeat (16) @(posedge aclk);
      end
    end
  endtask
  initial
  begin
    forever
    begin
      @(negedge txd);
      repeat (8) @(posedge aclk);
      for (j = 0; j < 8; j = j + 1)
      begin
        repeat (16) @(posedge aclk);
        sh = {txd, sh[7:1]};
      end
      got_q.push_back(sh);
      repeat (16) @(posedge aclk);
    end
  end
endmodule

/* verif/uart_runtime_regs_fifo_irq_tb.sv */
// Testbench of the runtime register block with a serial line peer.
// Assumes the divisor reset value of one, sixteen clocks per bit.
`timescale 1ns/1ns
`define CK(a, b) begin tests_run = tests_run + 1; if ((a) !== (b)) begin \
  n_mismatch = n_mismatch + 1; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
`define RC(i, e) begin rd(i); `CK(rd_v, {24'h00_0000, e}) end
module uart_runtime_regs_fifo_irq_tb;
  reg        aclk = 1'b0, aresetn = 1'b0, modem_change = 1'b0;
  reg [4:0]  s_axi_awaddr = 5'h00, s_axi_araddr = 5'h00;
  reg [31:0] s_axi_wdata = 32'h0000_0000, seed = 32'h0000_9c43, rd_v;
  reg [3:0]  s_axi_wstrb = 4'hf;
  reg        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  reg        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg [1:0]  rs_v;
  reg [7:0]  exp_q[$];
  wire       s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  wire       rxd, txd, serial_irq;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  integer    n_mismatch = 0, tests_run = 0, cyc = 0, k, s;
  always #5 aclk = ~aclk;
  urt_runtime dut_u (.*);
  urt_peer peer_u (.aclk(aclk), .txd(txd), .rxd(rxd));
  function [31:0] nxt(input [31:0] v);
    nxt = {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function [7:0] idv(input fe, input [3:0] c);
    idv = {fe, fe, 2'b00, c};
  endfunction
  function integer trig(input integer t);
    trig = (t == 0) ? 1 : (t == 1) ? 4 : (t == 2) ? 8 : 14;
  endfunction
  task wr(input [2:0] i, input [7:0] d);
    begin
      s_axi_awaddr <= {i, 2'b00};
      s_axi_wdata <= {24'h00_0000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= !i[0];
      @(posedge aclk);
      while (s_axi_awvalid || s_axi_wvalid || !s_axi_bready || !s_axi_bvalid)
      begin
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid) s_axi_bready <= 1'b1;
        @(posedge aclk);
      end
      rs_v = s_axi_bresp;
      s_axi_bready <= 1'b0;
      @(posedge aclk);
    end
  endtask
  task rd(input [2:0] i);
    begin
      s_axi_araddr <= {i, 2'b00};
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= !i[0];
      @(posedge aclk);
      while (s_axi_arvalid || !s_axi_rready || !s_axi_rvalid)
      begin
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid) s_axi_rready <= 1'b1;
        @(posedge aclk);
      end
      rd_v = s_axi_rdata;
      rs_v = s_axi_rresp;
      s_axi_rready <= 1'b0;
      @(posedge aclk);
    end
  endtask
  task snd;
    begin
      seed = nxt(seed);
      exp_q.push_back(seed[7:0]);
      peer_u.send(seed[7:0]);
    end
  endtask
  task final_report;
    begin
      $display("tests_run=%0d n_mismatch=%0d", tests_run, n_mismatch);
      if (n_mismatch == 0 && tests_run > 0)
        $display("No errors found");
      else
        $display("Errors were found");
      $finish;
    end
  endtask
  always @(posedge aclk)
  begin
    cyc = cyc + 1;
    if (cyc == 40000)
    begin
      n_mismatch = n_mismatch + 1;
      final_report;
    end
  end
  initial
  begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `RC(3'h1, 8'h00)
    `RC(3'h2, idv(1'b0, 4'h1))
    rd(3'h4);
    `CK({rs_v, rd_v}, {2'h2, 32'h0000_0000})
    wr(3'h6, 8'h11);
    `CK(rs_v, 2'h2)
    wr(3'h1, 8'hff);
    s_axi_wstrb <= 4'he;
    wr(3'h1, 8'h00);
    `CK(rs_v, 2'h0)
    s_axi_wstrb <= 4'hf;
    `RC(3'h1, 8'h0f)
    `RC(3'h2, idv(1'b0, 4'h2))
    `RC(3'h2, idv(1'b0, 4'h1))
    wr(3'h3, 8'h80);
    wr(3'h1, 8'h00);
    `RC(3'h1, 8'h00)
    wr(3'h3, 8'h00);
    `RC(3'h1, 8'h0f)
    $display("test registers done");
    wr(3'h1, 8'h08);
    wr(3'h2, 8'h39);
    modem_change <= 1'b1;
    `RC(3'h2, idv(1'b1, 4'h0))
    `CK(serial_irq, 1'b1)
    wr(3'h1, 8'h00);
    `RC(3'h2, idv(1'b1, 4'h1))
    `CK(serial_irq, 1'b0)
    wr(3'h1, 8'h0a);
    `RC(3'h2, idv(1'b1, 4'h2))
    `RC(3'h2, idv(1'b1, 4'h0))
    modem_change <= 1'b0;
    wr(3'h1, 8'h01);
    $display("test priority done");
    for (s = 0; s < 4; s = s + 1)
    begin
      wr(3'h2, {s[1:0], 6'h03});
      exp_q.delete();
      for (k = 1; k < trig(s); k = k + 1) snd;
      `RC(3'h2, idv(1'b1, 4'h1))
      snd;
      `RC(3'h2, idv(1'b1, 4'h4))
    end
    rd(3'h0);
    `CK(rd_v[7:0], exp_q.pop_front())
    repeat (700) @(posedge aclk);
    `RC(3'h2, idv(1'b1, 4'hc))
    for (k = 0; k < 13; k = k + 1)
    begin
      rd(3'h0);
      `CK(rd_v[7:0], exp_q.pop_front())
    end
    $display("test receive done");
    wr(3'h1, 8'h00);
    wr(3'h0, seed[15:8]);
    wr(3'h0, seed[23:16]);
    for (k = 0; k < 800 && peer_u.got_q.size() < 2; k = k + 1) @(posedge aclk);
    `CK({peer_u.got_q[1], peer_u.got_q[0]}, seed[23:8])
    snd;
    wr(3'h0, seed[7:0]);
    wr(3'h0, seed[31:24]);
    wr(3'h2, 8'h05);
    repeat (400) @(posedge aclk);
    `CK(peer_u.got_q.size(), 3)
    wr(3'h2, 8'h00);
    `RC(3'h2, idv(1'b0, 4'h1))
    rd(3'h5);
    `CK(rd_v[0], 1'b0)
    $display("test transmit done");
    final_report;
  end
endmodule
